/* File: dsrs_defs.vh */
// constants for the self-refresh scheduling block of a low-power dram
// assumes a 250 MHz core clock and a controller that keeps its own rules
// How it works
// [RULE1] controller may refresh once per average interval; self-refresh then anytime
// [RULE2] controller may burst many all-bank refreshes, then pause until window ends
// [RULE3] pause at most window minus count times four refresh cycle times
// [RULE4] pattern transitions keep required count in every rolling window
// [RULE5] switch to distributed refresh right after a burst, never after pause
// [RULE6] with burst/pause, enter self-refresh after burst, resume with burst
// [RULE7] entry: clock enable low now, high before, cs low, ca 0 0 1
// [RULE8] controller sends no-op after entry, holds clock enable low
// [RULE9] device refreshes by internal timer and gates its internal clock
// [RULE10] in self-refresh every input except clock enable is ignored
// [RULE11] at least one internal all-bank refresh within minimum residency
// [RULE12] controller stays in self-refresh at least the minimum residency
// [RULE13] external clock may stop one cycle after entry, stable before exit
// [RULE14] two stable clocks before clock enable rises for exit
// [RULE15] exit delay counts from first rising edge after clock enable high
// [RULE16] during exit delay only no-ops with clock enable high
// [RULE17] one all-bank refresh after exit before next self-refresh
// [RULE18] self-refresh only with all banks idle
// [RULE19] no refresh in power-down; controller limits power-down time
// [RULE20] four-bit bank mask written by mode register write
// [RULE21] masked banks are skipped during self-refresh
// [RULE22] unmasked banks refresh segments chosen by segment mask bits
// [RULE23] refresh: cs low, ca 0 0 1; ca3 low means per-bank
// [RULE24] at most eight all-bank refreshes per refresh-burst window
// [RULE25] self-refresh time lowers required count by time over interval, rounded up
// [RULE26] controller tracks refreshes and self-refresh time over sliding window
`ifndef DSRS_DEFS_VH
`define DSRS_DEFS_VH
`define DSRS_CLK_PS 4000
`define DSRS_REFI_NS 7800
`define DSRS_REFI_CYC ((`DSRS_REFI_NS * 1000) / `DSRS_CLK_PS)
`define DSRS_CKESR_NS 15
`define DSRS_CKESR_CYC (((`DSRS_CKESR_NS * 1000) + `DSRS_CLK_PS - 1) / `DSRS_CLK_PS)
`define DSRS_XSR_NS 140
`define DSRS_XSR_CYC (((`DSRS_XSR_NS * 1000) + `DSRS_CLK_PS - 1) / `DSRS_CLK_PS)
`define DSRS_RFC_NS 130
`define DSRS_RFC_CYC (((`DSRS_RFC_NS * 1000) + `DSRS_CLK_PS - 1) / `DSRS_CLK_PS)
`define DSRS_CNT_W 16
`define DSRS_BANKS 4
`define DSRS_SEGS 8
`define DSRS_MR_BANK_MASK 8'h10
`define DSRS_MR_SEG_MASK 8'h11
`define DSRS_ST_IDLE 2'h0
`define DSRS_ST_SREF 2'h1
`define DSRS_ST_EXIT 2'h2
`endif

/* File: dsrs_timer.v */
// down counter with load, used for residency, exit delay and refresh timer
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
`include "dsrs_defs.vh"
module dsrs_timer
(
   input wire core_clk_i,
   input wire rst_i,
   input wire load_i,
   input wire [`DSRS_CNT_W-1:0] value_i,
   input wire run_i,
   output wire zero_o
);
   reg [`DSRS_CNT_W-1:0] cnt_q;
   reg [`DSRS_CNT_W-1:0] cnt_d;
   always @*
   begin
      cnt_d = cnt_q;
      if (load_i)
      begin
         cnt_d = value_i;
      end
      else if (run_i && (cnt_q != {`DSRS_CNT_W{1'b0}}))
      begin
         cnt_d = cnt_q - {{(`DSRS_CNT_W-1){1'b0}}, 1'b1};
      end
   end
   always @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cnt_q <= {`DSRS_CNT_W{1'b0}};
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end
   assign zero_o = (cnt_q == {`DSRS_CNT_W{1'b0}});
endmodule // dsrs_timer

/* File: dsrs_core.v */
// self-refresh command decode, residency, exit delay and internal refresh
// assumes controller drives cke, cs and ca synchronous to core_clk_i
`timescale 1ns/1ps
`include "dsrs_defs.vh"
module dsrs_core
(
   input wire core_clk_i,
   input wire rst_i,
   input wire cke_i,
   input wire cs_n_i,
   input wire [3:0] ca_i,
   input wire mode_reg_write_cmd_i,
   input wire [7:0] mr_addr_i,
   input wire [7:0] mr_data_i,
   input wire banks_idle_i,
   output reg in_self_refresh_o,
   output reg exit_busy_o,
   output reg int_clk_gate_o,
   output reg allbank_refresh_cmd_o,
   output reg perbank_refresh_o,
   output reg [`DSRS_BANKS-1:0] bank_refresh_o,
   output reg [`DSRS_SEGS-1:0] seg_refresh_o,
   output reg [`DSRS_BANKS-1:0] bank_mask_o,
   output reg entry_error_o,
   output reg pd_active_o
);
   // ***********************************************
   // state and registers
   // ***********************************************
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg cke_prev_q;
   reg [`DSRS_SEGS-1:0] seg_mask_q;
   reg sr_refresh_done_q;
   localparam integer RESID_LD_INT = `DSRS_CKESR_CYC;
   localparam integer FIRST_LD_INT = `DSRS_CKESR_CYC - 1;
   localparam integer EXIT_LD_INT = `DSRS_XSR_CYC;
   localparam integer REFI_LD_INT = `DSRS_REFI_CYC;
   wire [`DSRS_CNT_W-1:0] resid_ld;
   wire [`DSRS_CNT_W-1:0] first_ld;
   wire [`DSRS_CNT_W-1:0] exit_ld;
   wire [`DSRS_CNT_W-1:0] refi_ld;
   wire refresh_cmd;
   wire sref_cmd;
   wire sref_entry;
   wire resid_zero;
   wire exit_zero;
   wire refi_zero;
   wire int_refresh;
   // ***********************************************
   // command decode
   // ***********************************************
   assign refresh_cmd = ~cs_n_i & ~ca_i[0] & ~ca_i[1] & ca_i[2]; // [RULE23]
   assign resid_ld = RESID_LD_INT[`DSRS_CNT_W-1:0];
   assign first_ld = FIRST_LD_INT[`DSRS_CNT_W-1:0];
   assign exit_ld = EXIT_LD_INT[`DSRS_CNT_W-1:0];
   assign refi_ld = REFI_LD_INT[`DSRS_CNT_W-1:0];
   assign sref_cmd = (state_q == `DSRS_ST_IDLE) & cke_prev_q & ~cke_i
      & refresh_cmd; // [RULE7]
   // entry refused while banks are busy [RULE18]
   assign sref_entry = sref_cmd & banks_idle_i;
   // ***********************************************
   // timers
   // ***********************************************
   dsrs_timer u_resid
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_i(sref_entry),
      .value_i(resid_ld),
      .run_i(state_q == `DSRS_ST_SREF),
      .zero_o(resid_zero)
   );
   dsrs_timer u_exit
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_i((state_q == `DSRS_ST_SREF) & cke_i), // [RULE15]
      .value_i(exit_ld),
      .run_i(state_q == `DSRS_ST_EXIT),
      .zero_o(exit_zero)
   );
   // internal refresh timer: first refresh fires when the DSRS_CKESR_CYC - 1 load counts out after entry [RULE9]
   dsrs_timer u_refi
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_i(sref_entry | int_refresh),
      .value_i(sref_entry ? first_ld : refi_ld), // [RULE11]
      .run_i(state_q == `DSRS_ST_SREF),
      .zero_o(refi_zero)
   );
   assign int_refresh = (state_q == `DSRS_ST_SREF) & refi_zero & ~sref_entry;
   // ***********************************************
   // state machine
   // ***********************************************
   always @*
   begin
      state_d = state_q;
      case (state_q)
         `DSRS_ST_IDLE:
         begin
            if (sref_entry)
            begin
               state_d = `DSRS_ST_SREF;
            end
         end
         `DSRS_ST_SREF:
         begin
            if (cke_i) // only cke is observed here [RULE10]
            begin
               state_d = `DSRS_ST_EXIT;
            end
         end
         `DSRS_ST_EXIT:
         begin
            if (exit_zero)
            begin
               state_d = `DSRS_ST_IDLE;
            end
         end
         default:
         begin
            state_d = `DSRS_ST_IDLE;
         end
      endcase
   end
   always @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state_q <= `DSRS_ST_IDLE;
         cke_prev_q <= 1'b0;
         seg_mask_q <= {`DSRS_SEGS{1'b0}};
         sr_refresh_done_q <= 1'b0;
         in_self_refresh_o <= 1'b0;
         exit_busy_o <= 1'b0;
         int_clk_gate_o <= 1'b0;
         allbank_refresh_cmd_o <= 1'b0;
         perbank_refresh_o <= 1'b0;
         bank_refresh_o <= {`DSRS_BANKS{1'b0}};
         seg_refresh_o <= {`DSRS_SEGS{1'b0}};
         bank_mask_o <= {`DSRS_BANKS{1'b0}};
         entry_error_o <= 1'b0;
         pd_active_o <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cke_prev_q <= cke_i;
         in_self_refresh_o <= (state_d == `DSRS_ST_SREF);
         exit_busy_o <= (state_d == `DSRS_ST_EXIT);
         int_clk_gate_o <= (state_d == `DSRS_ST_SREF); // [RULE9]
         // mask registers written only in idle, not in self-refresh or exit
         if (mode_reg_write_cmd_i && (state_q == `DSRS_ST_IDLE))
         begin
            if (mr_addr_i == `DSRS_MR_BANK_MASK)
            begin
               bank_mask_o <= mr_data_i[`DSRS_BANKS-1:0]; // [RULE20]
            end
            if (mr_addr_i == `DSRS_MR_SEG_MASK)
            begin
               seg_mask_q <= mr_data_i; // [RULE22]
            end
         end
         // external refresh only outside self-refresh and exit
         allbank_refresh_cmd_o <= (state_q == `DSRS_ST_IDLE) & cke_i & cke_prev_q
            & refresh_cmd & ca_i[3]; // [RULE23]
         perbank_refresh_o <= (state_q == `DSRS_ST_IDLE) & cke_i & cke_prev_q
            & refresh_cmd & ~ca_i[3]; // [RULE23]
         entry_error_o <= sref_cmd & ~banks_idle_i; // [RULE18]
         // power-down: cke low without entry, no refresh there
         pd_active_o <= (state_d == `DSRS_ST_IDLE) & ~cke_i & ~sref_entry; // [RULE19]
         if (sref_entry)
         begin
            sr_refresh_done_q <= 1'b0;
         end
         else if (int_refresh)
         begin
            sr_refresh_done_q <= 1'b1; // [RULE11]
         end
         if (int_refresh)
         begin
            bank_refresh_o <= ~bank_mask_o; // [RULE21]
            seg_refresh_o <= ~seg_mask_q; // [RULE22]
         end
         else
         begin
            bank_refresh_o <= {`DSRS_BANKS{1'b0}};
            seg_refresh_o <= {`DSRS_SEGS{1'b0}};
         end
      end
   end
   // residency counted but drives no output; early exit still honoured [RULE12]
   wire unused_resid;
   assign unused_resid = resid_zero & sr_refresh_done_q;
endmodule // dsrs_core

/* File: dsrs_props.sv */
// assertions on the ports of the self-refresh core
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dsrs_props
(
   input wire core_clk_i,
   input wire rst_i,
   input wire cke_i,
   input wire cs_n_i,
   input wire [3:0] ca_i,
   input wire mode_reg_write_cmd_i,
   input wire [7:0] mr_addr_i,
   input wire [7:0] mr_data_i,
   input wire banks_idle_i,
   input wire in_self_refresh_o,
   input wire exit_busy_o,
   input wire int_clk_gate_o,
   input wire allbank_refresh_cmd_o,
   input wire perbank_refresh_o,
   input wire [3:0] bank_refresh_o,
   input wire [7:0] seg_refresh_o,
   input wire [3:0] bank_mask_o,
   input wire entry_error_o,
   input wire pd_active_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire idle_w = !in_self_refresh_o && !exit_busy_o;
   wire cmd_w = idle_w && !cs_n_i && ca_i[2:0] == 3'b100;
   property p_entry;
      cmd_w && banks_idle_i && !cke_i && $past(cke_i && !rst_i) |=> in_self_refresh_o;
   endproperty
   a_entry: assert property (p_entry) else $error("entry missed");
   property p_err;
      cmd_w && !banks_idle_i && !cke_i && $past(cke_i) |=> entry_error_o && !in_self_refresh_o;
   endproperty
   a_err: assert property (p_err) else $error("busy entry taken");
   property p_gate;
      int_clk_gate_o == in_self_refresh_o;
   endproperty
   a_gate: assert property (p_gate) else $error("clock gate wrong");
   property p_ign;
      in_self_refresh_o && !cke_i |=> in_self_refresh_o && !allbank_refresh_cmd_o
         && !perbank_refresh_o && $stable(bank_mask_o);
   endproperty
   a_ign: assert property (p_ign) else $error("input obeyed in self-refresh");
   property p_exit;
      in_self_refresh_o && cke_i |=> !in_self_refresh_o && exit_busy_o;
   endproperty
   a_exit: assert property (p_exit) else $error("exit start wrong");
   property p_xsr;
      $rose(exit_busy_o) |-> ##35 exit_busy_o ##1 !exit_busy_o;
   endproperty
   a_xsr: assert property (p_xsr) else $error("exit delay length");
   property p_allbank_refresh_cmd;
      cmd_w && ca_i[3] && cke_i && $past(cke_i) |=> allbank_refresh_cmd_o;
   endproperty
   a_allbank_refresh_cmd: assert property (p_allbank_refresh_cmd) else $error("all-bank refresh missed");
   property p_refpb;
      cmd_w && !ca_i[3] && cke_i && $past(cke_i) |=> perbank_refresh_o;
   endproperty
   a_refpb: assert property (p_refpb) else $error("per-bank refresh missed");
   property p_mask;
      |bank_refresh_o |-> bank_refresh_o == ~bank_mask_o;
   endproperty
   a_mask: assert property (p_mask) else $error("masked bank refreshed");
   property p_int;
      $rose(in_self_refresh_o) && !(&bank_mask_o) |-> ##[0:8] (|bank_refresh_o);
   endproperty
   a_int: assert property (p_int) else $error("no internal refresh");
   property p_pd;
      pd_active_o |-> bank_refresh_o == 4'h0;
   endproperty
   a_pd: assert property (p_pd) else $error("refresh in power-down");
   property p_mrw;
      mode_reg_write_cmd_i && mr_addr_i == 8'h10 && idle_w && cke_i
         |=> bank_mask_o == $past(mr_data_i[3:0]);
   endproperty
   a_mrw: assert property (p_mrw) else $error("bank mask not written");
   c_sref: cover property ($rose(in_self_refresh_o));
   c_exit: cover property ($fell(exit_busy_o));
   c_err: cover property (entry_error_o);
endmodule // dsrs_props
bind dsrs_core dsrs_props i_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .cke_i(cke_i),
   .cs_n_i(cs_n_i), .ca_i(ca_i), .mode_reg_write_cmd_i(mode_reg_write_cmd_i),
   .mr_addr_i(mr_addr_i), .mr_data_i(mr_data_i), .banks_idle_i(banks_idle_i),
   .in_self_refresh_o(in_self_refresh_o), .exit_busy_o(exit_busy_o),
   .int_clk_gate_o(int_clk_gate_o), .allbank_refresh_cmd_o(allbank_refresh_cmd_o),
   .perbank_refresh_o(perbank_refresh_o), .bank_refresh_o(bank_refresh_o),
   .seg_refresh_o(seg_refresh_o), .bank_mask_o(bank_mask_o),
   .entry_error_o(entry_error_o), .pd_active_o(pd_active_o));

/* File: dsrs_ctl_model.sv */
// controller model driving clock enable, chip select and command bits
// assumes the bench calls its tasks; lines change on the falling edge
`timescale 1ns/1ps
module dsrs_ctl_model
(
   input wire core_clk_i,
   output reg cke_o,
   output reg cs_n_o,
   output reg [3:0] ca_o
);
   initial
   begin
      cke_o = 1'b0;
      cs_n_o = 1'b1;
      ca_o = 4'h0;
   end
   task cmd(input c, input s, input [3:0] a);
   begin
      @(negedge core_clk_i);
      cke_o = c;
      cs_n_o = s;
      ca_o = a;
   end
   endtask
   // junk lines stand for inputs the device ignores
   task idle(input c, input j, input integer n);
      integer i;
   begin
      for (i = 0; i < n; i = i + 1)
         if (j) cmd(c, $urandom, $urandom);
         else cmd(c, 1'b1, 4'h0);
   end
   endtask
   task sref(input integer n);
   begin
      cmd(1'b1, 1'b1, 4'h0);
      cmd(1'b0, 1'b0, 4'h4);
      idle(1'b0, 1'b0, 1);
      idle(1'b0, 1'b1, n);
      idle(1'b0, 1'b0, 2);
      idle(1'b1, 1'b0, 38);
      cmd(1'b1, 1'b0, 4'hc);
      idle(1'b1, 1'b0, 2);
   end
   endtask
endmodule // dsrs_ctl_model

/* File: tb.sv */
// self-checking bench for the self-refresh core
// assumes the controller model drives the command lines
`timescale 1ns/1ps
module tb;
   reg core_clk_i;
   reg rst_i;
   reg mode_reg_write_cmd;
   reg idl;
   reg [7:0] ma;
   reg [7:0] md;
   reg [3:0] em;
   reg [7:0] es;
   reg r;
   wire cke, cs_n, sr, xb, gate, ab, pb, err, pd;
   wire [3:0] ca, br, bm;
   wire [7:0] sg;
   integer failures, n_checks, cyc, nab, npb, ner, nxb, nb, bad, eab, epb, k, nb0;
   dsrs_ctl_model i_ctl (.core_clk_i(core_clk_i), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));
   dsrs_core i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cke_i(cke), .cs_n_i(cs_n),
      .ca_i(ca), .mode_reg_write_cmd_i(mode_reg_write_cmd), .mr_addr_i(ma), .mr_data_i(md),
      .banks_idle_i(idl), .in_self_refresh_o(sr), .exit_busy_o(xb), .int_clk_gate_o(gate),
      .allbank_refresh_cmd_o(ab), .perbank_refresh_o(pb), .bank_refresh_o(br),
      .seg_refresh_o(sg), .bank_mask_o(bm), .entry_error_o(err), .pd_active_o(pd));
   task chk(input ok, input [127:0] m);
   begin
      n_checks = n_checks + 1;
      if (ok !== 1'b1)
      begin
         failures = failures + 1;
         $display("[ERR] %0t %0s", $time, m);
      end
   end
   endtask
   task end_sim;
   begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   task mw(input [7:0] a, input [7:0] d);
   begin
      @(negedge core_clk_i);
      mode_reg_write_cmd = 1'b1;
      ma = a;
      md = d;
      @(negedge core_clk_i);
      mode_reg_write_cmd = 1'b0;
   end
   endtask
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i)
   begin
      cyc = cyc + 1;
      if (cyc > 3000)
      begin
         failures = failures + 1;
         end_sim;
      end
      if (!rst_i)
      begin
         nab = nab + ab;
         npb = npb + pb;
         ner = ner + err;
         nxb = nxb + xb;
         nb = nb + (br != 4'h0);
         if (br !== 4'h0 && (br !== ~em || sg !== ~es || pd)) bad = bad + 1;
      end
   end
   initial
   begin
      {failures, n_checks, cyc, nab, npb, ner, nxb, nb, bad, eab, epb} = 0;
      {rst_i, mode_reg_write_cmd, idl, ma, md} = 19'h50000;
      bad = $urandom(32'hbef4);
      bad = 0;
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk({sr, xb, ab, pb, br, sg, bm, err, pd} === 21'h0, "reset");
      em = $urandom;
      es = $urandom;
      if (em == 4'hf) em = 4'h6;
      mw(8'h10, {4'h0, em});
      mw(8'h11, es);
      i_ctl.idle(1'b1, 1'b0, 2);
      chk(bm === em, "bank mask");
      for (k = 0; k < 6; k = k + 1)
      begin
         r = $urandom;
         eab = eab + r;
         epb = epb + !r;
         i_ctl.cmd(1'b1, 1'b0, {r, 3'h4});
         i_ctl.idle(1'b1, 1'b0, 1);
      end
      i_ctl.idle(1'b1, 1'b0, 2);
      chk(nab === eab && npb === epb, "refresh count");
      idl = 1'b0;
      i_ctl.cmd(1'b0, 1'b0, 4'h4);
      i_ctl.idle(1'b1, 1'b0, 3);
      chk(ner === 1 && sr === 1'b0, "busy entry");
      idl = 1'b1;
      i_ctl.sref(20);
      chk(nb > 0 && bad === 0, "masked refresh");
      chk(nxb === 36 && nab === eab + 1 && npb === epb, "exit");
      nb0 = nb;
      i_ctl.idle(1'b0, 1'b0, 6);
      chk(pd === 1'b1 && sr === 1'b0, "power-down");
      i_ctl.idle(1'b1, 1'b0, 4);
      chk(nb === nb0 && bad === 0, "pd refresh");
      end_sim;
   end
endmodule // tb
